// ==== hw/csc_pkg.sv ====
package csc_pkg;

  // Register word addresses
  localparam logic [15:0] CSC_LEVELS_ADDR  = 16'hFF00;
  localparam logic [15:0] CSC_OUTEN_ADDR   = 16'hFF01;
  localparam logic [15:0] CSC_START_ADDR   = 16'hFF02;
  localparam logic [15:0] CSC_IRQFLG_ADDR  = 16'hFF03;
  localparam logic [15:0] CSC_IRQMSK_ADDR  = 16'hFF04;
  localparam logic [15:0] CSC_ACTEN_ADDR   = 16'hFF05;
  localparam logic [15:0] CSC_STATUS_ADDR  = 16'hFF06;
  localparam logic [15:0] CSC_FLGCLR_ADDR  = 16'hFF07;
  localparam logic [15:0] CSC_IRQCLR_ADDR  = 16'hFF08;
  localparam logic [15:0] CSC_DATA_ADDR    = 16'hFF10;

  // Field positions
  localparam int CSC_CLK_LVL_BIT   = 8;
  localparam int CSC_DATA_LVL_BIT  = 0;
  localparam int CSC_OUTEN_BIT     = 0;
  localparam int CSC_START_BIT     = 0;
  localparam int CSC_XEND_BIT      = 5;
  localparam int CSC_OVRIRQ_BIT    = 0;
  localparam int CSC_ACT_BIT       = 3;
  localparam int CSC_OVF_BIT       = 0;
  localparam int CSC_BUSY_BIT      = 6;
  localparam int CSC_RXFULL_BIT    = 5;
  localparam int CSC_OPER_BIT      = 7;
  localparam int CSC_OVCLR_BIT     = 0;

  // Reset values
  localparam logic [15:0] CSC_LEVELS_RST = 16'h0101;
  localparam logic [15:0] CSC_OUTEN_RST  = 16'h0000;
  localparam logic [7:0]  CSC_IRQMSK_RST = 8'hFF;
  localparam logic [7:0]  CSC_ACTEN_RST  = 8'h00;

  // Serial timing
  localparam int CSC_CLK_PERIOD_NS  = 10;
  localparam int CSC_SCK_PERIOD_NS  = 160;
  localparam int CSC_HALF_CYCLES    =
    (CSC_SCK_PERIOD_NS / 2) / CSC_CLK_PERIOD_NS;
  localparam int CSC_FRAME_BITS     = 8;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } csc_bus_req_t;

  // Serial pin group driven by the channel
  typedef struct packed {
    logic sck;
    logic sckOe;
    logic sdo;
    logic sdoOe;
  } csc_pins_t;

endpackage : csc_pkg

// ==== hw/csc_bit_timer.sv ====
`timescale 1ns/1ps

// Input synchroniser and half-period tick divider
module csc_bit_timer
  import csc_pkg::*;
#(
  parameter int HALF_CYCLES = CSC_HALF_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic sdiPin,
  output logic      sdiSync,
  output logic      tick
);

  // Refuse divider lengths the 8-bit counter cannot hold
  if (HALF_CYCLES < 1 || HALF_CYCLES > 255) begin : g_bad_half
    $error("csc_bit_timer: HALF_CYCLES out of range");
  end

  localparam logic [7:0] LAST = 8'(HALF_CYCLES - 1);

  logic       sdiMeta_reg;
  logic       sdiSync_reg;
  logic [7:0] div_reg;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser for serial data in
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdiMeta_reg <= 1'b0;
      sdiSync_reg <= 1'b0;
    end else begin
      sdiMeta_reg <= sdiPin;
      sdiSync_reg <= sdiMeta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider, held at zero while idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 8'h00;
    end else if (!run || div_reg == LAST) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign sdiSync = sdiSync_reg;
  assign tick    = run && (div_reg == LAST);

endmodule : csc_bit_timer

// ==== hw/csc_channel.sv ====
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module csc_channel
  import csc_pkg::*;
#(
  parameter int HALF_CYCLES = CSC_HALF_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire csc_bus_req_t busReq,
  output logic [15:0]       rdata,
  input  wire logic         sdiPin,
  output csc_pins_t         pins,
  output logic              irq,
  output logic              xferReq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [1:0] {
    CSC_ST_OFF,
    CSC_ST_WAIT,
    CSC_ST_SHIFT
  } csc_state_t;

  csc_state_t  state_reg;
  logic [15:0] levels_reg;
  logic [15:0] outEn_reg;
  logic [7:0]  irqFlg_reg;
  logic [7:0]  irqMsk_reg;
  logic [7:0]  actEn_reg;
  logic        ovf_reg;
  logic        rxFull_reg;
  logic [7:0]  txShift_reg;
  logic [7:0]  rxShift_reg;
  logic [7:0]  rxData_reg;
  logic [2:0]  bitCnt_reg;
  logic        half_reg;
  logic [15:0] rdata_reg;
  logic        xferReq_reg;
  logic        sdiSync;
  logic        tick;
  logic        frameDone;
  logic        overrun;
  logic        wrLevels;
  logic        wrOutEn;
  logic        wrStart;
  logic        wrIrqFlg;
  logic        wrIrqMsk;
  logic        wrActEn;
  logic        wrFlgClr;
  logic        wrIrqClr;
  logic        wrData;
  logic        rdData;
  logic        clkLvl;
  logic        dataLvl;
  logic        outOn;
  csc_pins_t   pins_reg;
  csc_pins_t   pins_next;
  logic [15:0] statusWord;

  // Last bit index of a frame
  localparam logic [2:0] LAST_BIT = 3'(CSC_FRAME_BITS - 1);

  // Address match helper
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  // Write strobe carrying a one in a trigger bit
  function automatic logic wrOne(input logic        sel,
                                 input logic [15:0] d,
                                 input int          b);
    wrOne = sel && d[b];
  endfunction : wrOne

  // Refuse settings the divider and byte registers cannot serve
  if (HALF_CYCLES < 1 || HALF_CYCLES > 255) begin : g_bad_half
    $error("csc_channel: HALF_CYCLES out of range");
  end
  if (CSC_XEND_BIT > 7 || CSC_ACT_BIT > 7) begin : g_bad_field
    $error("csc_channel: byte register field out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign wrLevels = busReq.wr && hit(busReq.addr, CSC_LEVELS_ADDR);
  assign wrOutEn  = busReq.wr && hit(busReq.addr, CSC_OUTEN_ADDR);
  assign wrStart  = busReq.wr && hit(busReq.addr, CSC_START_ADDR);
  assign wrIrqFlg = busReq.wr && hit(busReq.addr, CSC_IRQFLG_ADDR);
  assign wrIrqMsk = busReq.wr && hit(busReq.addr, CSC_IRQMSK_ADDR);
  assign wrActEn  = busReq.wr && hit(busReq.addr, CSC_ACTEN_ADDR);
  assign wrFlgClr = busReq.wr && hit(busReq.addr, CSC_FLGCLR_ADDR);
  assign wrIrqClr = busReq.wr && hit(busReq.addr, CSC_IRQCLR_ADDR);
  assign wrData   = busReq.wr && hit(busReq.addr, CSC_DATA_ADDR);
  assign rdData   = busReq.rd && hit(busReq.addr, CSC_DATA_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and bit timing
  csc_bit_timer #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .run     (state_reg == CSC_ST_SHIFT),
    .sdiPin  (sdiPin),
    .sdiSync (sdiSync),
    .tick    (tick)
  );

  assign frameDone = tick && half_reg && (bitCnt_reg == LAST_BIT);
  assign overrun   = frameDone && rxFull_reg && !rdData;

  ////////////////////////////////////////////////////////////////////////
  // Idle level register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      levels_reg <= CSC_LEVELS_RST;
    end else if (wrLevels) begin
      levels_reg <= busReq.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enable register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outEn_reg <= CSC_OUTEN_RST;
    end else if (wrOutEn) begin
      outEn_reg <= busReq.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqMsk_reg <= CSC_IRQMSK_RST;
    end else if (wrIrqMsk) begin
      irqMsk_reg <= busReq.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer activation enable register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      actEn_reg <= CSC_ACTEN_RST;
    end else if (wrActEn) begin
      actEn_reg <= busReq.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel sequencer: off, waiting for data, shifting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CSC_ST_OFF;
    end else begin
      case (state_reg)
        CSC_ST_OFF: begin
          if (wrOne(wrStart, busReq.wdata, CSC_START_BIT)) begin
            state_reg <= CSC_ST_WAIT;
          end
        end
        CSC_ST_WAIT: begin
          if (wrData) begin
            state_reg <= CSC_ST_SHIFT;
          end
        end
        CSC_ST_SHIFT: begin
          if (frameDone) begin
            state_reg <= CSC_ST_WAIT;
          end
        end
        default: begin
          state_reg <= CSC_ST_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine, MSB first, sample on return to idle level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txShift_reg <= 8'h00;
      rxShift_reg <= 8'h00;
      bitCnt_reg  <= 3'h0;
      half_reg    <= 1'b0;
    end else if (state_reg == CSC_ST_WAIT && wrData) begin
      txShift_reg <= busReq.wdata[7:0];
      bitCnt_reg  <= 3'h0;
      half_reg    <= 1'b0;
    end else if (tick) begin
      half_reg <= !half_reg;
      if (!half_reg) begin
        rxShift_reg <= {rxShift_reg[6:0], sdiSync};
      end else begin
        txShift_reg <= {txShift_reg[6:0], 1'b0};
        bitCnt_reg  <= bitCnt_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive holding byte and its unread marker
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxData_reg <= 8'h00;
      rxFull_reg <= 1'b0;
    end else if (frameDone) begin
      rxData_reg <= rxShift_reg;
      rxFull_reg <= 1'b1;
    end else if (rdData) begin
      rxFull_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overrun flag, a new error wins over a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_reg <= 1'b0;
    end else if (overrun) begin
      ovf_reg <= 1'b1;
    end else if (wrOne(wrFlgClr, busReq.wdata, CSC_OVCLR_BIT)) begin
      ovf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky request flags, events win over clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqFlg_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if ((i == CSC_XEND_BIT && frameDone) ||
            (i == CSC_OVRIRQ_BIT && overrun)) begin
          irqFlg_reg[i] <= 1'b1;
        end else if (wrIrqClr && busReq.wdata[i]) begin
          irqFlg_reg[i] <= 1'b0;
        end else if (wrIrqFlg) begin
          irqFlg_reg[i] <= busReq.wdata[i];
        end
      end
    end
  end

  // Level interrupt; mask gates service, not the flag
  assign irq = |(irqFlg_reg & ~irqMsk_reg);

  ////////////////////////////////////////////////////////////////////////
  // Transfer controller activation pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xferReq_reg <= 1'b0;
    end else begin
      xferReq_reg <= frameDone && actEn_reg[CSC_ACT_BIT];
    end
  end

  assign xferReq = xferReq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pin drive
  assign clkLvl  = levels_reg[CSC_CLK_LVL_BIT];
  assign dataLvl = levels_reg[CSC_DATA_LVL_BIT];
  assign outOn   = outEn_reg[CSC_OUTEN_BIT] && (state_reg == CSC_ST_SHIFT);

  // Next pin values, idle levels unless the shifter owns the pins
  always_comb begin
    pins_next.sck   = clkLvl;
    pins_next.sdo   = dataLvl;
    pins_next.sckOe = 1'b1;
    pins_next.sdoOe = 1'b1;
    if (outOn) begin
      pins_next.sck = half_reg ? clkLvl : !clkLvl;
      pins_next.sdo = txShift_reg[7];
    end
  end

  // Pins leave flip-flops so the link clock cannot glitch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_reg.sck   <= CSC_LEVELS_RST[CSC_CLK_LVL_BIT];
      pins_reg.sckOe <= 1'b1;
      pins_reg.sdo   <= CSC_LEVELS_RST[CSC_DATA_LVL_BIT];
      pins_reg.sdoOe <= 1'b1;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign pins = pins_reg;

  ////////////////////////////////////////////////////////////////////////
  // Status word as software reads it
  always_comb begin
    statusWord                 = 16'h0000;
    statusWord[CSC_OVF_BIT]    = ovf_reg;
    statusWord[CSC_BUSY_BIT]   = (state_reg == CSC_ST_SHIFT);
    statusWord[CSC_RXFULL_BIT] = rxFull_reg;
    statusWord[CSC_OPER_BIT]   = (state_reg != CSC_ST_OFF);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else if (busReq.rd) begin
      case (busReq.addr)
        CSC_LEVELS_ADDR: rdata_reg <= levels_reg;
        CSC_OUTEN_ADDR:  rdata_reg <= outEn_reg;
        CSC_IRQFLG_ADDR: rdata_reg <= {8'h00, irqFlg_reg};
        CSC_IRQMSK_ADDR: rdata_reg <= {8'h00, irqMsk_reg};
        CSC_ACTEN_ADDR:  rdata_reg <= {8'h00, actEn_reg};
        CSC_STATUS_ADDR: rdata_reg <= statusWord;
        CSC_DATA_ADDR:   rdata_reg <= {8'h00, rxData_reg};
        default:         rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign rdata = rdata_reg;

endmodule : csc_channel

// ==== verification/csc_channel_assertions.sv ====
`timescale 1ns/1ps
module csc_channel_assertions
  import csc_pkg::*;
#(
  parameter int HALF_CYCLES = CSC_HALF_CYCLES
) (
  input wire logic         clk,
  input wire logic         rstn,
  input wire csc_bus_req_t busReq,
  input wire logic [15:0]  rdata,
  input wire logic         sdiPin,
  input wire csc_pins_t    pins,
  input wire logic         irq,
  input wire logic         xferReq
);
  localparam int FHI = 16 * HALF_CYCLES + 4;
  logic [15:0] lvlReg;
  logic [7:0]  mskReg;
  logic        actReg;
  logic        oeReg;
  logic        runReg;
  int          cntReg;

  function automatic logic hit(input logic [15:0] a);
    return busReq.wr && busReq.addr == a;
  endfunction : hit

  wire logic datWr = busReq.wr && busReq.addr == CSC_DATA_ADDR && runReg;

  // Shadow of the settings; counter spans one frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvlReg <= CSC_LEVELS_RST;
      mskReg <= CSC_IRQMSK_RST;
      actReg <= 1'h0;
      oeReg  <= 1'h0;
      runReg <= 1'h0;
      cntReg <= 0;
    end else begin
      if (hit(CSC_LEVELS_ADDR)) lvlReg <= busReq.wdata;
      if (hit(CSC_IRQMSK_ADDR)) mskReg <= busReq.wdata[7:0];
      if (hit(CSC_ACTEN_ADDR)) actReg <= busReq.wdata[CSC_ACT_BIT];
      if (hit(CSC_OUTEN_ADDR)) oeReg <= busReq.wdata[CSC_OUTEN_BIT];
      if (hit(CSC_START_ADDR) && busReq.wdata[0]) runReg <= 1'h1;
      if (datWr) cntReg <= 16 * HALF_CYCLES + 2;
      else if (cntReg != 0) cntReg <= cntReg - 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////
  a_rdata_idle: assert property (
    !busReq.rd |=> rdata == 16'h0000) else $error("stray read data");
  a_idle_levels: assert property (
    cntReg == 0 |-> pins.sck == $past(lvlReg[8])
      && pins.sdo == $past(lvlReg[0]))
    else $error("idle pin level wrong");
  a_outen_off: assert property (
    !oeReg |-> pins.sck == $past(lvlReg[8])
      && pins.sdo == $past(lvlReg[0]))
    else $error("pins moved while output disabled");
  a_frame_start: assert property (
    datWr && cntReg == 0 && oeReg |=> ##1 pins.sck != lvlReg[8]
      && pins.sdo == $past(busReq.wdata[7], 2)) else $error("frame start");
  a_xfer_bound: assert property (
    datWr && cntReg == 0 && actReg |-> ##[1:FHI] xferReq)
    else $error("no transfer request after frame");
  a_xfer_single: assert property (
    xferReq |=> !xferReq) else $error("transfer request too long");
  a_xfer_off: assert property (
    !actReg |-> !xferReq) else $error("transfer request while disabled");
  a_irq_mask: assert property (
    busReq.rd && busReq.addr == CSC_IRQFLG_ADDR
      |=> $past(irq) == |(rdata[7:0] & ~mskReg))
    else $error("interrupt disagrees with flags and mask");

  c_frame: cover property (datWr && cntReg == 0 && oeReg);
  c_xfer: cover property (xferReq);
  c_masked: cover property (busReq.rd && mskReg[5] && irq == 1'h0);
endmodule : csc_channel_assertions

bind csc_channel csc_channel_assertions #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .busReq(busReq), .rdata(rdata), .sdiPin(sdiPin),
  .pins(pins), .irq(irq), .xferReq(xferReq));

// ==== verification/csc_slave_model.sv ====
`timescale 1ns/1ps
module csc_slave_model (
  input  wire logic       rstn,
  input  wire logic       sck,
  input  wire logic       sdo,
  input  wire logic [7:0] txByte,
  output logic            sdi,
  output logic [7:0]      rxByte
);
  int idx;

  // Falling clock shows next bit MSB first, rising clock samples
  always @(sck or negedge rstn) begin
    if (!rstn) begin
      idx = 0;
      sdi = 1'h0;
    end else if (!sck) begin
      sdi = txByte[7 - idx];
    end else begin
      rxByte = {rxByte[6:0], sdo};
      idx = (idx + 1) % 8;
      if (idx == 0) sdi = ~sdi; // Line inverts after the eighth bit so it keeps no stale bit
    end
  end
endmodule : csc_slave_model

// ==== verification/csc_channel_tb.sv ====
`timescale 1ns/1ps
module csc_channel_tb
  import csc_pkg::*;
;
  logic         clk;
  logic         rstn;
  logic         slvRstn;
  csc_bus_req_t busReq;
  logic [15:0]  rdata;
  logic         sdiPin;
  csc_pins_t    pins;
  logic         irq;
  logic         xferReq;
  logic [7:0]   slvTx;
  logic [7:0]   slvRx;
  logic [15:0]  seen;
  int           errors;
  int           num_checks;
  int           xferCount = 0;

  always #5 clk = ~clk;

  csc_channel u_dut (.clk(clk), .rstn(rstn), .busReq(busReq),
    .rdata(rdata), .sdiPin(sdiPin), .pins(pins), .irq(irq),
    .xferReq(xferReq));
  csc_slave_model u_slave (.rstn(slvRstn), .sck(pins.sck),
    .sdo(pins.sdo), .txByte(slvTx), .sdi(sdiPin), .rxByte(slvRx));

  // Count transfer requests
  always @(negedge clk) if (xferReq === 1'h1) xferCount++;

  ////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // One bus cycle, read data caught in the slot after it
  task automatic acc(input logic w, input logic [15:0] a, d);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= w;
    busReq.rd    <= !w;
    @(posedge clk);
    busReq.wr <= 1'h0;
    busReq.rd <= 1'h0;
    @(negedge clk);
    seen = rdata;
    @(posedge clk);
  endtask : acc

  task automatic rdc(input string n, input logic [15:0] a, e);
    acc(1'h0, a, 16'h0000);
    check(n, seen, e);
  endtask : rdc

  // Pin levels looked at mid-cycle, after the registered pins settle
  task automatic pchk(input string n, input logic [15:0] e);
    @(negedge clk);
    check(n, {14'h0000, pins.sck, pins.sdo}, e);
    @(posedge clk);
  endtask : pchk

  task automatic frame(input logic [7:0] tx, stx);
    int k;
    slvTx = stx;
    acc(1'h1, CSC_IRQCLR_ADDR, 16'h0021);
    acc(1'h1, CSC_DATA_ADDR, {8'h00, tx});
    for (k = 0; k < 400 && irq !== 1'h1; k++) @(negedge clk);
    @(posedge clk);
    if (k == 400) errors++;
    if (k == 400) conclude();
    check("slave rx", {8'h00, slvRx}, {8'h00, tx});
  endtask : frame

  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    slvRstn = 1'h0;
    busReq = '0;
    slvTx = 8'h00;
    errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rdc("levels", CSC_LEVELS_ADDR, 16'h0101);
    rdc("mask", CSC_IRQMSK_ADDR, 16'h00FF);
    rdc("activation", CSC_ACTEN_ADDR, 16'h0000);
    rdc("status", CSC_STATUS_ADDR, 16'h0000);
    rdc("unmapped", 16'hFF20, 16'h0000);
    check("pin drive", {14'h0000, pins.sckOe, pins.sdoOe}, 16'h0003);
    $display("test reset done");
    acc(1'h1, CSC_LEVELS_ADDR, 16'h0001);
    pchk("idle pins", 16'h0001);
    acc(1'h1, CSC_LEVELS_ADDR, 16'h0100);
    pchk("idle pins", 16'h0002);
    acc(1'h1, CSC_DATA_ADDR, 16'h00FF);
    acc(1'h1, CSC_START_ADDR, 16'h0000);
    rdc("status", CSC_STATUS_ADDR, 16'h0000);
    acc(1'h1, CSC_OUTEN_ADDR, 16'h0001);
    slvRstn <= 1'h1;
    acc(1'h1, CSC_START_ADDR, 16'h0001);
    rdc("start", CSC_START_ADDR, 16'h0000);
    rdc("status", CSC_STATUS_ADDR, 16'h0080);
    $display("test setup done");
    acc(1'h1, CSC_ACTEN_ADDR, 16'h0008);
    acc(1'h1, CSC_IRQMSK_ADDR, 16'h00DF);
    frame(8'h3C, 8'hA5);
    check("xfer count", 16'(xferCount), 16'h0001);
    check("irq", {15'h0000, irq}, 16'h0001);
    rdc("flags", CSC_IRQFLG_ADDR, 16'h0020);
    rdc("data", CSC_DATA_ADDR, 16'h00A5);
    acc(1'h1, CSC_IRQMSK_ADDR, 16'h00FF);
    check("irq", {15'h0000, irq}, 16'h0000);
    rdc("flags", CSC_IRQFLG_ADDR, 16'h0020);
    $display("test exchange done");
    acc(1'h1, CSC_ACTEN_ADDR, 16'h0000);
    acc(1'h1, CSC_IRQMSK_ADDR, 16'h00DF);
    frame(8'h5A, 8'h81);
    rdc("status", CSC_STATUS_ADDR, 16'h00A0);
    frame(8'hC3, 8'h7E);
    check("xfer count", 16'(xferCount), 16'h0001);
    rdc("status", CSC_STATUS_ADDR, 16'h00A1);
    rdc("flags", CSC_IRQFLG_ADDR, 16'h0021);
    acc(1'h1, CSC_FLGCLR_ADDR, 16'h0000);
    rdc("status", CSC_STATUS_ADDR, 16'h00A1);
    acc(1'h1, CSC_FLGCLR_ADDR, 16'h0001);
    rdc("status", CSC_STATUS_ADDR, 16'h00A0);
    rdc("data", CSC_DATA_ADDR, 16'h007E);
    $display("test overrun done");
    acc(1'h1, CSC_OUTEN_ADDR, 16'h0000);
    acc(1'h1, CSC_DATA_ADDR, 16'h0055);
    repeat (140) pchk("quiet pins", 16'h0002);
    rdc("status", CSC_STATUS_ADDR, 16'h00A0);
    $display("test quiet output done");
    conclude();
  end
endmodule : csc_channel_tb
